// ### hw/i2c_slave_config_access.v
// serial-bus slave giving an outside master access to config registers
`timescale 1ns/1ps
`include "i2c_cfg_regs.vh"
`default_nettype none

module i2c_slave_config_access (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // serial bus pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    // address strap pins
    input wire [2:0] addr_strap,
    // internal register access port
    output reg reg_req,
    output reg reg_we,
    output reg [3:0] reg_port,
    output reg [11:0] reg_addr,
    output reg [3:0] reg_be,
    output reg [31:0] reg_wdata,
    input wire reg_ack,
    input wire [31:0] reg_rdata,
    // slave address register load from the link side
    input wire link_cfg_we,
    input wire [31:0] link_cfg_wdata,
    output reg [31:0] slave_cfg
);

    reg scl_m_ff, scl_s_ff, scl_d_ff;
    reg sda_m_ff, sda_s_ff, sda_d_ff;
    reg [2:0] strap_m_ff, strap_s_ff;
    reg [2:0] st_ff;
    reg [3:0] bit_ff;
    reg [7:0] shr_ff;
    reg addr_ph_ff;
    reg rw_ff;
    reg [2:0] cnt_ff;
    reg [2:0] got_ff;
    reg [1:0] txi_ff;
    reg busy_ff;
    reg [7:0] c0_ff, c1_ff, c2_ff, c3_ff;
    reg [31:0] wdat_ff;
    reg [31:0] buf_ff;

    wire scl_rise = scl_s_ff & ~scl_d_ff;
    wire scl_fall = ~scl_s_ff & scl_d_ff;
    wire bus_start = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
    wire bus_stop = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

    // open-drain: only ever pulls low
    assign sda_out = 1'b0;

    function sel_ok;
        input [3:0] sel;
        begin
            case (sel)
                4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE:
                    sel_ok = 1'b1;
                default:
                    sel_ok = 1'b0;
            endcase
        end
    endfunction

    function [3:0] lane_mask;
        input [2:0] n;
        begin
            case (n)
                3'h1: lane_mask = 4'h8;
                3'h2: lane_mask = 4'hC;
                3'h3: lane_mask = 4'hE;
                3'h4: lane_mask = 4'hF;
                default: lane_mask = 4'h0;
            endcase
        end
    endfunction

    wire [3:0] cmd_sel = {c1_ff[2:0], c2_ff[7]};
    wire [11:0] cmd_addr = {c2_ff[1:0], c3_ff, 2'b00};
    wire [3:0] cmd_be = c2_ff[5:2];
    // reserved bits, codes or selectors spoil the command
    wire cmd_clean = (c0_ff[7:3] == 5'h00) && (c1_ff[7:3] == 5'h00) &&
                     ~c2_ff[6] && sel_ok(cmd_sel);
    wire cmd_wr = cmd_clean && (c0_ff[2:0] == `OP_WRITE);
    wire cmd_rd = cmd_clean && (c0_ff[2:0] == `OP_READ);
    // the address register lives here, and only in port 0 space
    wire cmd_local = (cmd_sel == `SLV_CFG_PORT) &&
                     (cmd_addr == `SLV_CFG_OFF);
    wire [6:0] my_addr = {slave_cfg[`SLV_ADDR_HI:`SLV_ADDR_LO],
                          strap_s_ff};
    wire [3:0] wr_be = cmd_be & lane_mask(got_ff);
    // kept at two bits so the lane index wraps 0 -> 3 when indexing
    wire [1:0] nxt_txi = txi_ff - 2'h1;
    // a write is flushed when its packet ends, so short writes still land
    wire commit = (bus_start | bus_stop) && cmd_wr && (got_ff != 3'h0) &&
                  (wr_be != 4'h0) && ~busy_ff;
    wire rd_go = (st_ff == `ST_ACK) && scl_fall && ~rw_ff &&
                 (cnt_ff == `CMD_BYTES) && cmd_rd;

    // pin synchronisers; the first stage feeds only the second
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_m_ff <= 1'b1;
            scl_s_ff <= 1'b1;
            scl_d_ff <= 1'b1;
            sda_m_ff <= 1'b1;
            sda_s_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            strap_m_ff <= 3'h7;
            strap_s_ff <= 3'h7;
        end else begin
            scl_m_ff <= scl_in;
            scl_s_ff <= scl_m_ff;
            scl_d_ff <= scl_s_ff;
            sda_m_ff <= sda_in;
            sda_s_ff <= sda_m_ff;
            sda_d_ff <= sda_s_ff;
            strap_m_ff <= addr_strap;
            strap_s_ff <= strap_m_ff;
        end
    end

    // address register: loaded from the link side, never from the bus
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slave_cfg <= `SLV_CFG_RST;
        end else if (link_cfg_we) begin
            slave_cfg <= link_cfg_wdata;
        end
    end

    // bus protocol engine; matches addresses against my_addr, the upper slave_cfg bits plus the strap pins
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= `ST_IDLE;
            bit_ff <= 4'h0;
            shr_ff <= 8'h00;
            addr_ph_ff <= 1'b0;
            rw_ff <= 1'b0;
            cnt_ff <= 3'h0;
            got_ff <= 3'h0;
            txi_ff <= `TOP_LANE;
            sda_oe <= 1'b0;
            c0_ff <= 8'h00;
            c1_ff <= 8'h00;
            c2_ff <= 8'h00;
            c3_ff <= 8'h00;
            wdat_ff <= 32'h00000000;
        end else if (bus_start) begin
            // repeated start may join command and read packets
            st_ff <= `ST_RXB;
            bit_ff <= 4'h0;
            addr_ph_ff <= 1'b1;
            got_ff <= 3'h0;
            sda_oe <= 1'b0;
        end else if (bus_stop) begin
            st_ff <= `ST_IDLE;
            got_ff <= 3'h0;
            sda_oe <= 1'b0;
        end else begin
            case (st_ff)
                `ST_RXB: begin
                    if (scl_rise) begin
                        shr_ff <= {shr_ff[6:0], sda_s_ff};
                        bit_ff <= bit_ff + 4'h1;
                    end else if (scl_fall && bit_ff == `BITS_PER_BYTE) begin
                        bit_ff <= 4'h0;
                        if (addr_ph_ff) begin
                            addr_ph_ff <= 1'b0;
                            if (shr_ff[7:1] == my_addr) begin
                                rw_ff <= shr_ff[0];
                                cnt_ff <= 3'h0;
                                txi_ff <= `TOP_LANE;
                                sda_oe <= 1'b1;
                                st_ff <= `ST_ACK;
                            end else begin
                                st_ff <= `ST_IDLE;
                            end
                        end else begin
                            case (cnt_ff)
                                3'h0: c0_ff <= shr_ff;
                                3'h1: c1_ff <= shr_ff;
                                3'h2: c2_ff <= shr_ff;
                                3'h3: c3_ff <= shr_ff;
                                // first data byte lands in byte 3
                                3'h4: wdat_ff[31:24] <= shr_ff;
                                3'h5: wdat_ff[23:16] <= shr_ff;
                                3'h6: wdat_ff[15:8] <= shr_ff;
                                default: wdat_ff[7:0] <= shr_ff;
                            endcase
                            if (cnt_ff >= `CMD_BYTES) begin
                                got_ff <= got_ff + 3'h1;
                            end
                            cnt_ff <= cnt_ff + 3'h1;
                            // eighth byte after the address is refused
                            sda_oe <= (cnt_ff != `NAK_INDEX);
                            st_ff <= `ST_ACK;
                        end
                    end
                end
                `ST_ACK: begin
                    if (scl_fall) begin
                        if (rw_ff) begin
                            // send buffer, byte 3 first
                            shr_ff <= buf_ff[8 * txi_ff +: 8];
                            sda_oe <= ~buf_ff[8 * txi_ff + 7];
                            bit_ff <= 4'h0;
                            st_ff <= `ST_TXB;
                        end else begin
                            sda_oe <= 1'b0;
                            // a refused byte leaves the rest of the packet
                            if (!sda_oe) begin
                                st_ff <= `ST_WAIT;
                            end else begin
                                st_ff <= `ST_RXB;
                            end
                        end
                    end
                end
                `ST_TXB: begin
                    if (scl_rise) begin
                        bit_ff <= bit_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_ff == `BITS_PER_BYTE) begin
                            sda_oe <= 1'b0;
                            st_ff <= `ST_RACK;
                        end else begin
                            sda_oe <= ~shr_ff[6];
                            shr_ff <= {shr_ff[6:0], 1'b0};
                        end
                    end
                end
                `ST_RACK: begin
                    if (scl_rise && sda_s_ff) begin
                        st_ff <= `ST_WAIT;
                    end else if (scl_fall) begin
                        // lane index wraps 0 -> 3 by plain decrement
                        txi_ff <= nxt_txi;
                        shr_ff <= buf_ff[8 * nxt_txi +: 8];
                        sda_oe <= ~buf_ff[8 * nxt_txi + 7];
                        bit_ff <= 4'h0;
                        st_ff <= `ST_TXB;
                    end
                end
                `ST_WAIT: begin
                    sda_oe <= 1'b0;
                end
                default: begin
                    sda_oe <= 1'b0;
                    st_ff <= `ST_IDLE;
                end
            endcase
        end
    end

    // register access requests and the read buffer
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_req <= 1'b0;
            reg_we <= 1'b0;
            reg_port <= 4'h0;
            reg_addr <= 12'h000;
            reg_be <= 4'h0;
            reg_wdata <= 32'h00000000;
            busy_ff <= 1'b0;
            buf_ff <= 32'h00000000;
        end else begin
            reg_req <= 1'b0;
            if (busy_ff && reg_ack) begin
                busy_ff <= 1'b0;
                if (!reg_we) begin
                    buf_ff <= reg_rdata;
                end
            end
            if (commit && !cmd_local) begin
                // address register is never written from the bus
                reg_req <= 1'b1;
                reg_we <= 1'b1;
                reg_port <= cmd_sel;
                reg_addr <= cmd_addr;
                reg_be <= wr_be;
                reg_wdata <= wdat_ff;
                busy_ff <= 1'b1;
            end else if (rd_go && cmd_local) begin
                buf_ff <= slave_cfg;
            end else if (rd_go && !busy_ff) begin
                reg_req <= 1'b1;
                reg_we <= 1'b0;
                reg_port <= cmd_sel;
                reg_addr <= cmd_addr;
                reg_be <= cmd_be;
                busy_ff <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ### hw/i2c_cfg_regs.vh
// constants for the serial configuration-access slave
`ifndef I2C_CFG_REGS_VH
`define I2C_CFG_REGS_VH

// slave address configuration register, port 0 space only
`define SLV_CFG_PORT 4'h0
`define SLV_CFG_OFF 12'h294
`define SLV_CFG_RST 32'h0000005F
// slave address layout: upper bits from the register, low bits strapped
`define SLV_ADDR_HI 6
`define SLV_ADDR_LO 3

// command byte 0 operation codes
`define OP_WRITE 3'h3
`define OP_READ 3'h4

// bit and byte counts and indices within a packet
`define BITS_PER_BYTE 4'h8
`define CMD_BYTES 3'h4
`define NAK_INDEX 3'h7
`define TOP_LANE 2'h3

// bus protocol state machine, receive and transmit
`define ST_IDLE 3'h0
`define ST_RXB 3'h1
`define ST_ACK 3'h2
`define ST_TXB 3'h3
`define ST_RACK 3'h4
`define ST_WAIT 3'h5

`endif

// ### tb/i2c_cfg_access_properties.sv
// assertions for the serial configuration-access slave
`timescale 1ns/1ps
`default_nettype none
module i2c_cfg_access_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_oe,
    // register access port
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic [3:0] reg_port,
    input wire logic [11:0] reg_addr,
    input wire logic [3:0] reg_be,
    // address register
    input wire logic link_cfg_we,
    input wire logic [31:0] link_cfg_wdata,
    input wire logic [31:0] slave_cfg
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence oe_hold;
        sda_oe [*8];
    endsequence
    sequence stop_cond;
        scl_in && $rose(sda_in);
    endsequence
    AST_ADDR_ALIGN: assert property (
        reg_req |-> reg_addr[1:0] == 2'h0)
        else $error("request address not dword aligned");
    AST_PORT_VALID: assert property (
        reg_req |-> reg_port inside
        {4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE})
        else $error("request to an invalid port selector");
    AST_CFG_INTERNAL: assert property (
        reg_req |-> !(reg_port == 4'h0 && reg_addr == 12'h294))
        else $error("address register access left the block");
    AST_CFG_LOAD: assert property (
        link_cfg_we |=> slave_cfg[6:0] == $past(link_cfg_wdata[6:0]))
        else $error("address register did not load");
    AST_CFG_HOLD: assert property (
        !link_cfg_we |=> $stable(slave_cfg))
        else $error("address register changed without a load");
    AST_WR_BE: assert property (
        reg_req && reg_we |-> reg_be != 4'h0)
        else $error("write request with no byte enabled");
    AST_WR_AT_END: assert property (
        reg_req && reg_we |-> scl_in)
        else $error("write issued before the packet ended");
    AST_RD_AT_ACK: assert property (
        reg_req && !reg_we |-> !scl_in)
        else $error("read issued outside the command ack clock");
    AST_SDA_SCL_LOW: assert property (
        $changed(sda_oe) |-> !scl_in)
        else $error("data line moved while the bus clock was high");
    AST_OE_HOLD: assert property (
        $rose(sda_oe) |-> oe_hold)
        else $error("pulled-low bit too short");
    cover property (stop_cond ##[1:8] reg_req);
endmodule
bind i2c_slave_config_access i2c_cfg_access_checker chk_u (
    .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_oe(sda_oe), .reg_req(reg_req), .reg_we(reg_we),
    .reg_port(reg_port), .reg_addr(reg_addr), .reg_be(reg_be),
    .link_cfg_we(link_cfg_we), .link_cfg_wdata(link_cfg_wdata),
    .slave_cfg(slave_cfg));
`default_nettype wire

// ### tb/i2c_master_model.sv
// behavioural bus master driving the serial clock and open-drain data
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    // serial bus
    output var logic scl,
    output var logic sda_low,
    input wire logic sda
);
    // 125 ns bus clock, standing high between frames
    localparam realtime Q = 31.25;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // from a low clock this gives a repeated start
    task automatic start();
        sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask
    // nak high releases the ack bit; d of FF releases data for reads
    task automatic xfer(input logic [7:0] d, input logic nak,
                        output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 8; i >= 0; i--) begin
            sda_low = (i > 0) ? ~d[i - 1] : ~nak;
            #Q scl = 1'b1;
            #Q r = sda;
            #Q scl = 1'b0;
            if (i > 0)
                q[i - 1] = r;
            ack = ~r;
            #Q;
        end
    endtask
endmodule
`default_nettype wire

// ### tb/i2c_slave_config_access_test.sv
// self-checking bench for the serial configuration-access slave
`timescale 1ns/1ps
`default_nettype none
`include "i2c_cfg_regs.vh"
module i2c_slave_config_access_test;
    logic clock, rst_n, link_cfg_we, reg_ack = 1'b0;
    logic [2:0] addr_strap;
    logic [31:0] reg_rdata, link_cfg_wdata;
    wire logic sda_out, sda_oe, reg_req, reg_we, scl, sda_low;
    wire logic [3:0] reg_port, reg_be;
    wire logic [11:0] reg_addr;
    wire logic [31:0] reg_wdata, slave_cfg;
    wire logic sda = !(sda_oe || sda_low);
    logic [7:0] req_cnt = 8'h00;
    logic [6:0] sa = 7'h5F;
    int error_cnt = 0, checked = 0, cyc = 0;
    i2c_master_model m_u (.scl(scl), .sda_low(sda_low), .sda(sda));
    i2c_slave_config_access dut_u (
        .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
        .reg_req(reg_req), .reg_we(reg_we), .reg_port(reg_port),
        .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
        .reg_ack(reg_ack), .reg_rdata(reg_rdata),
        .link_cfg_we(link_cfg_we), .link_cfg_wdata(link_cfg_wdata),
        .slave_cfg(slave_cfg));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // register side answers each request one cycle later
    always @(posedge clock) begin
        reg_ack <= reg_req;
        if (reg_req === 1'b1)
            req_cnt <= req_cnt + 8'h01;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic summarize();
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s,
                         input logic [31:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic put(input logic [7:0] d, input logic hit);
        logic [7:0] q;
        logic a;
        m_u.xfer(d, 1'b1, q, a);
        check("ack", a, hit);
    endtask
    task automatic cmd(input logic [31:0] c, input int nd,
                       input logic [31:0] d, input logic hit);
        m_u.start();
        put({sa, 1'b0}, hit);
        for (int i = 3; i >= 0; i--)
            put(c[8 * i +: 8], hit);
        for (int i = 0; i < nd; i++)
            put(d[31 - 8 * i -: 8], hit && i < 3);
    endtask
    // command packet, repeated start, then five bytes to see the wrap
    task automatic rd(input logic [31:0] c, input logic [31:0] e);
        logic [7:0] q;
        logic a;
        cmd(c, 0, 32'h0, 1'b1);
        m_u.start();
        put({sa, 1'b1}, 1'b1);
        for (int i = 0; i < 5; i++) begin
            m_u.xfer(8'hFF, i == 4, q, a);
            check("rdata", q, e[31 - 8 * (i % 4) -: 8]);
        end
        m_u.stop();
    endtask
    task automatic t_write();
        logic [7:0] n0;
        n0 = req_cnt;
        cmd({5'h0, `OP_WRITE, 24'h043C14}, 4, 32'h12345678,
            1'b1);
        m_u.stop();
        repeat (10) @(posedge clock);
        check("wcnt", req_cnt - n0, 8'h01);
        check("we", reg_we, 1'b1);
        check("port", reg_port, 4'h8);
        check("addr", reg_addr, 12'h050);
        check("be", reg_be, 4'hF);
        check("wdata", reg_wdata, 32'h12345678);
        cmd({5'h0, `OP_WRITE, 24'h00BCFF}, 1, 32'hAB000000, 1'b1);
        m_u.stop();
        repeat (10) @(posedge clock);
        check("port1", reg_port, 4'h1);
        check("addr1", reg_addr, 12'h3FC);
        check("be1", reg_be, 4'h8);
        check("wd1", reg_wdata[31:24], 8'hAB);
    endtask
    task automatic t_invalid();
        logic [31:0] bad [5] = '{32'h0B043C14, 32'h030C3C14, 32'h03047C14,
                                 32'h0301BC14, 32'h0305BC14};
        logic [7:0] n0;
        n0 = req_cnt;
        for (int k = 0; k < 8; k++) begin
            if (k != 3 && k != 4) begin
                cmd({5'h0, k[2:0], 24'h043C14}, 4, 32'h0, 1'b1);
                m_u.stop();
            end
        end
        for (int k = 0; k < 5; k++) begin
            cmd(bad[k], 4, 32'h0, 1'b1);
            m_u.stop();
        end
        repeat (10) @(posedge clock);
        check("icnt", req_cnt - n0, 8'h00);
    endtask
    task automatic t_read();
        logic [7:0] n0;
        n0 = req_cnt;
        rd({5'h0, `OP_READ, 24'h043C49}, 32'hABCDEF01);
        check("rcnt", req_cnt - n0, 8'h01);
        check("rwe", reg_we, 1'b0);
        check("rport", reg_port, 4'h8);
        check("raddr", reg_addr, 12'h124);
    endtask
    task automatic t_addr();
        logic [7:0] n0;
        @(posedge clock);
        link_cfg_wdata <= 32'h00000040;
        link_cfg_we <= 1'b1;
        addr_strap <= 3'b110;
        @(posedge clock);
        link_cfg_we <= 1'b0;
        repeat (4) @(posedge clock);
        check("cfg", slave_cfg, 32'h00000040);
        cmd({5'h0, `OP_WRITE, 24'h043C14}, 1, 32'h0, 1'b0);
        m_u.stop();
        sa = 7'h46;
        n0 = req_cnt;
        rd({5'h0, `OP_READ, 24'h003CA5}, 32'h00000040);
        check("ccnt", req_cnt - n0, 8'h00);
    endtask
    initial begin
        rst_n = 1'b0;
        link_cfg_we = 1'b0;
        link_cfg_wdata = 32'h0;
        addr_strap = 3'b111;
        reg_rdata = 32'hABCDEF01;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        check("cfg0", slave_cfg, `SLV_CFG_RST);
        check("oe0", sda_oe, 1'b0);
        check("sout", sda_out, 1'b0);
        t_write();
        t_invalid();
        t_read();
        t_addr();
        summarize();
    end
endmodule
`default_nettype wire
